// ==== verif/etf_chk_monitor.sv ====
/*
  Port checker for etf_monitor.
  Assumes it is bound to the monitor from the bench top.
*/
`timescale 1ns/100ps
`default_nettype none
module etf_chk (
  // Clock, reset and inputs.
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic extended_control_mode_i,
  input wire logic [31:0] program_status_word_i,
  input wire etf_pkg::etf_event_type event_i,
  input wire logic reg_read_i,
  // Outputs.
  input wire logic [31:0] reg_rdata_o,
  input wire logic program_int_o,
  input wire logic [7:0] int_code_o,
  input wire logic [23:0] int_instr_addr_o,
  input wire etf_pkg::etf_store_type store_o
);
  logic [3:0] ev_q;
  logic [23:0] ia_q;
  always_ff @(posedge clock_i) begin
    ev_q <= {event_i.store, event_i.fetch, event_i.greg_write, event_i.branch_taken};
    ia_q <= event_i.instr_addr;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_idle_quiet: assert property (
    !(extended_control_mode_i && program_status_word_i[1]) |=> !program_int_o)
    else $error("interrupt while inactive");
  a_no_event: assert property (ev_q == 4'h0 |-> !program_int_o)
    else $error("interrupt without event");
  a_code_class: assert property (program_int_o |-> int_code_o[7:4] != 4'h0 &&
    (int_code_o[7:4] & ~ev_q) == 4'h0 && int_code_o[3:0] == 4'h0)
    else $error("bad event code");
  a_addr_taken: assert property (program_int_o |-> int_instr_addr_o == ia_q)
    else $error("bad instruction address");
  a_code_store: assert property (program_int_o |=> store_o.valid &&
    store_o.location == 24'd150 && store_o.data[7:0] == int_code_o)
    else $error("bad code store");
  a_addr_store: assert property (program_int_o |-> ##2 store_o.valid &&
    store_o.location == 24'd153 && store_o.data[23:0] == int_instr_addr_o)
    else $error("bad address store");
  a_store_cause: assert property (
    store_o.valid |-> $past(program_int_o) || $past(program_int_o, 2))
    else $error("stray store");
  a_read_data: assert property (reg_rdata_o != 32'h0 |-> $past(reg_read_i))
    else $error("stray read data");
endmodule : etf_chk
`default_nettype wire

// ==== verif/etf_cpu.sv ====
/*
  CPU event source model: issues one-cycle event reports to the monitor.
  Assumes the monitor samples on the rising clock.
*/
`timescale 1ns/100ps
`default_nettype none
module etf_cpu (
  // Clock and event report.
  input wire logic clock_i,
  output var etf_pkg::etf_event_type event_o
);
  initial event_o = '0;
  // Released flags and register number read zero and addresses show inverted values so stale data never looks valid.
  task automatic fire(input logic [3:0] c, input logic [3:0] g,
    input logic [31:0] a, input logic [23:0] ia);
    @(posedge clock_i);
    event_o <= {c[0], c[1], g, c[2], c[3], a, ia};
    @(posedge clock_i);
    event_o <= {8'h00, ~a, ~ia};
  endtask : fire
endmodule : etf_cpu
`default_nettype wire

// ==== verif/tb_top.sv ====
/*
  Self-checking bench for etf_monitor driven through a CPU event model.
  Assumes etf_pkg, etf_cpu and etf_chk are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic mode = 1'b1;
  logic xlat = 1'b0;
  logic [31:0] sw = 32'h2;
  logic [3:0] ra = 4'h0;
  logic [31:0] wd = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic rd_q = 1'b0;
  etf_pkg::etf_event_type ev;
  logic [31:0] rdata, s, lo, hi, a, st, lc, la;
  logic pint, irq;
  logic [7:0] code;
  logic [23:0] iaddr;
  logic [31:0] eq[$];
  logic [31:0] rq[$];
  integer seed = 32'h96f1;
  int error_cnt = 0;
  int checks = 0;
  int i;
  always #5 clock_i = ~clock_i;
  etf_cpu u_cpu (.clock_i(clock_i), .event_o(ev));
  etf_monitor u_dut (.clock_i(clock_i), .rst_i(rst_i), .extended_control_mode_i(mode),
    .program_status_word_i(sw), .address_translation_i(xlat), .event_i(ev),
    .reg_addr_i(ra), .reg_wdata_i(wd), .reg_write_i(wr_s), .reg_read_i(rd_s),
    .reg_rdata_o(rdata), .program_int_o(pint), .int_code_o(code),
    .int_instr_addr_o(iaddr), .store_o(), .irq_o(irq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clock_i);
    ra <= ad;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clock_i);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] ad, input logic [31:0] e);
    @(posedge clock_i);
    ra <= ad;
    rd_s <= 1'b1;
    rq.push_back(e);
    @(posedge clock_i);
    rd_s <= 1'b0;
  endtask : rd
  task automatic fire(input logic [3:0] c, input logic [3:0] g);
    logic [3:0] hit;
    logic [23:0] ia;
    @(posedge clock_i);
    ia = 24'($random(seed));
    hit = c & s[3:0] & {{2{a >= lo && a <= hi}}, s[16 + g], 1'b1};
    hit = hit & {4{mode && sw[1]}};
    if (hit != 4'h0) eq.push_back({hit, 4'h0, ia});
    if (hit != 4'h0) lc = {24'h0, hit, 4'h0};
    if (hit != 4'h0) la = {8'h0, ia};
    st = st | {28'h0, hit};
    u_cpu.fire(c, g, a, ia);
    repeat (3) @(posedge clock_i);
  endtask : fire
  always @(posedge clock_i) begin
    rd_q <= rd_s;
    if (rd_q) check(rdata, rq.pop_front());
    if (pint === 1'b1) check({code, iaddr}, eq.size() > 0 ? eq.pop_front() : 32'hx);
  end
  initial begin
    st = 32'h0;
    lc = 32'h0;
    la = 32'h0;
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(4'h0, etf_pkg::ETF_SELECT_RESET);
    rd(4'hf, 32'h0);
    for (i = 0; i < 60; i++) begin
      if (i % 10 == 0) begin
        s = $random(seed);
        lo = $random(seed) & 32'h7fff_ffff;
        hi = lo + 32'h40;
        wr(4'h0, s);
        wr(4'h1, lo);
        wr(4'h2, hi);
        rd(4'h2, hi);
      end
      mode <= (i % 7 != 3);
      sw <= {30'h0, i % 9 != 4, 1'b0};
      xlat <= i[0];
      a = (i % 5 == 0) ? lo - 32'h1 : (i % 5 == 1) ? lo : (i % 5 == 2) ? hi : hi + 32'h1;
      if (i % 5 == 4) a = $random(seed);
      fire(4'($random(seed)), 4'($random(seed)));
    end
    wr(4'h5, 32'hff);
    rd(4'h5, lc);
    rd(4'h6, la);
    wr(4'h4, 32'hf);
    repeat (2) @(posedge clock_i);
    #1 check({31'h0, irq}, {31'h0, st != 32'h0});
    wr(4'h4, 32'h0);
    repeat (2) @(posedge clock_i);
    #1 check({31'h0, irq}, 32'h0);
    rd(4'h3, st);
    wr(4'h3, st);
    rd(4'h3, 32'h0);
    repeat (2) @(posedge clock_i);
    check(32'(eq.size()), 32'h0);
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    close_out();
  end
endmodule : tb_top
bind etf_monitor etf_chk u_chk (.clock_i(clock_i), .rst_i(rst_i),
  .extended_control_mode_i(extended_control_mode_i),
  .program_status_word_i(program_status_word_i), .event_i(event_i),
  .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .program_int_o(program_int_o),
  .int_code_o(int_code_o), .int_instr_addr_o(int_instr_addr_o), .store_o(store_o));
`default_nettype wire

// ==== verilog/etf_monitor.sv ====
/*
  Event trace facility monitor: watches branches, general register writes,
  instruction fetches and stores reported by the CPU, raises the program
  interruption request and writes the event code and instruction address
  to fixed storage. Assumes the CPU holds its event report for one cycle
  and accepts the fixed-storage writes as they are issued.
*/
// How it works
// - Monitor idles unless extended control mode and status word bit 1 are set.
// - Four classes: branch, register write, fetch in range, store in range.
// - Select register bits 0 to 3 enable the four classes individually.
// - Interruption only when status word mask and class enable are both set.
// - Select register bits 16 to 31 pick which of 16 registers count.
// - Start and end registers bound the range used for fetch and store.
// - On interruption the event code goes to fixed location 150.
// - On interruption the instruction address goes to locations 153 to 155.
// - Events seen while masked are dropped; nothing stays pending.
// - With address translation on, bounds compare against virtual addresses.
`timescale 1ns/100ps
`default_nettype none

module etf_monitor (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Processor state.
  input wire logic extended_control_mode_i,
  input wire logic [31:0] program_status_word_i,
  input wire logic address_translation_i,
  // Event reports from the CPU.
  input wire etf_pkg::etf_event_type event_i,
  // Register port.
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [31:0] reg_rdata_o,
  // Interruption and fixed storage writes.
  output logic program_int_o,
  output logic [7:0] int_code_o,
  output logic [23:0] int_instr_addr_o,
  output etf_pkg::etf_store_type store_o,
  output logic irq_o
);

  logic [31:0] select;
  logic [31:0] range_start;
  logic [31:0] range_end;
  logic [3:0] status;
  logic [3:0] irq_mask;
  logic [7:0] last_code;
  logic [23:0] last_addr;
  logic [31:0] rdata;
  logic prog_int;
  logic [7:0] code_q;
  logic [23:0] iaddr_q;
  logic irq;

  // Store sequencer: code first, then instruction address.
  typedef enum logic [2:0] {
    ETF_IDLE_ST = 3'b001,
    ETF_CODE_ST = 3'b010,
    ETF_ADDR_ST = 3'b100
  } etf_state_type;

  etf_state_type state;
  etf_pkg::etf_store_type store_q;

  logic [31:0] next_select;
  logic [31:0] next_range_start;
  logic [31:0] next_range_end;
  logic [3:0] next_status;
  logic [3:0] next_irq_mask;
  logic [7:0] next_last_code;
  logic [23:0] next_last_addr;
  logic [31:0] next_rdata;
  logic next_prog_int;
  logic [7:0] next_code_q;
  logic [23:0] next_iaddr_q;
  logic next_irq;
  etf_state_type next_state;
  etf_pkg::etf_store_type next_store_q;

  logic active;
  logic in_range;
  logic [3:0] raw_hits;
  logic [3:0] hits;
  logic above_start;
  logic below_end;
  logic [3:0] class_en;
  logic [15:0] greg_sel;

  // Decode of the class and register select register.
  always_comb begin
    class_en = select[etf_pkg::ETF_CLASS_STORE:etf_pkg::ETF_CLASS_BRANCH];
    greg_sel = select[etf_pkg::ETF_GREG_SEL_LSB +: 16];
  end

  // The monitor runs only in extended control mode with the status word mask set.
  always_comb begin
    active = extended_control_mode_i
      && program_status_word_i[etf_pkg::ETF_STATUS_WORD_MASK_BIT];
  end

  // The CPU reports a virtual address while translation is on, so the same
  // compare serves both modes. Both bounds are inclusive.
  always_comb begin
    above_start = event_i.access_addr >= range_start;
    below_end = event_i.access_addr <= range_end;
    in_range = above_start && below_end;
  end

  // Raw class detection, before any enable is applied.
  always_comb begin
    raw_hits[etf_pkg::ETF_CLASS_BRANCH] = event_i.branch_taken;
    raw_hits[etf_pkg::ETF_CLASS_GREG] = event_i.greg_write && greg_sel[event_i.greg_num];
    raw_hits[etf_pkg::ETF_CLASS_FETCH] = event_i.fetch && in_range;
    raw_hits[etf_pkg::ETF_CLASS_STORE] = event_i.store && in_range;
  end

  // Masked events simply vanish here; nothing is kept for later delivery.
  always_comb begin
    hits = raw_hits & class_en & {4{active}};
  end

  // Configuration registers, written from the register port.
  always_comb begin
    next_select = select;
    next_range_start = range_start;
    next_range_end = range_end;
    next_irq_mask = irq_mask;
    if (reg_write_i) begin
      case (reg_addr_i)
        etf_pkg::ETF_OFF_SELECT: begin
          next_select = reg_wdata_i;
        end
        etf_pkg::ETF_OFF_START: begin
          next_range_start = reg_wdata_i;
        end
        etf_pkg::ETF_OFF_END: begin
          next_range_end = reg_wdata_i;
        end
        etf_pkg::ETF_OFF_MASK: begin
          next_irq_mask = reg_wdata_i[3:0];
        end
        default: begin
          next_select = select;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      select <= etf_pkg::ETF_SELECT_RESET;
      range_start <= etf_pkg::ETF_START_RESET;
      range_end <= etf_pkg::ETF_END_RESET;
      irq_mask <= etf_pkg::ETF_IRQ_MASK_RESET;
    end else begin
      select <= next_select;
      range_start <= next_range_start;
      range_end <= next_range_end;
      irq_mask <= next_irq_mask;
    end
  end

  // Event capture: sticky status, interruption pulse and the recorded event.
  always_comb begin
    next_status = status;
    next_prog_int = 1'b0;
    next_code_q = code_q;
    next_iaddr_q = iaddr_q;
    next_last_code = last_code;
    next_last_addr = last_addr;
    if (reg_write_i && (reg_addr_i == etf_pkg::ETF_OFF_STATUS)) begin
      next_status = status & ~reg_wdata_i[3:0];
    end
    // A new event wins over a clear in the same cycle, so no event is lost.
    next_status = next_status | hits;
    if (|hits) begin
      next_prog_int = 1'b1;
      next_code_q = {hits, 4'h0};
      next_iaddr_q = event_i.instr_addr;
      next_last_code = {hits, 4'h0};
      next_last_addr = event_i.instr_addr;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      status <= 4'h0;
      prog_int <= 1'b0;
      code_q <= 8'h00;
      iaddr_q <= 24'h00_0000;
      last_code <= 8'h00;
      last_addr <= 24'h00_0000;
    end else begin
      status <= next_status;
      prog_int <= next_prog_int;
      code_q <= next_code_q;
      iaddr_q <= next_iaddr_q;
      last_code <= next_last_code;
      last_addr <= next_last_addr;
    end
  end

  // Fixed storage writes: the code word first, then the instruction address.
  // Events in back-to-back cycles are not each stored in full; the
  // writes then carry the latest recorded values.
  always_comb begin
    next_state = state;
    next_store_q = '0;
    case (state)
      ETF_IDLE_ST: begin
        if (|hits) begin
          next_state = ETF_CODE_ST;
        end
      end
      ETF_CODE_ST: begin
        next_store_q.valid = 1'b1;
        next_store_q.location = etf_pkg::ETF_LOC_CODE;
        next_store_q.data = {24'h00_0000, code_q};
        next_state = ETF_ADDR_ST;
      end
      ETF_ADDR_ST: begin
        next_store_q.valid = 1'b1;
        next_store_q.location = etf_pkg::ETF_LOC_ADDR;
        next_store_q.data = {8'h00, iaddr_q};
        next_state = (|hits) ? ETF_CODE_ST : ETF_IDLE_ST;
      end
      default: begin
        next_state = ETF_IDLE_ST;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= ETF_IDLE_ST;
      store_q <= '0;
    end else begin
      state <= next_state;
      store_q <= next_store_q;
    end
  end

  // Level interrupt from the unmasked sticky status bits.
  always_comb begin
    next_irq = |(next_status & next_irq_mask);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // Read data stand for one cycle after the read strobe and read zero otherwise.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_read_i) begin
      case (reg_addr_i)
        etf_pkg::ETF_OFF_SELECT: begin
          next_rdata = select;
        end
        etf_pkg::ETF_OFF_START: begin
          next_rdata = range_start;
        end
        etf_pkg::ETF_OFF_END: begin
          next_rdata = range_end;
        end
        etf_pkg::ETF_OFF_STATUS: begin
          next_rdata = {28'h000_0000, status};
        end
        etf_pkg::ETF_OFF_MASK: begin
          next_rdata = {28'h000_0000, irq_mask};
        end
        etf_pkg::ETF_OFF_CODE: begin
          next_rdata = {24'h00_0000, last_code};
        end
        etf_pkg::ETF_OFF_ADDR: begin
          next_rdata = {8'h00, last_addr};
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign reg_rdata_o = rdata;
  assign program_int_o = prog_int;
  assign int_code_o = code_q;
  assign int_instr_addr_o = iaddr_q;
  assign store_o = store_q;
  assign irq_o = irq;

endmodule : etf_monitor

`default_nettype wire

// ==== verilog/etf_pkg.sv ====
/*
  Package for the event trace facility: register offsets, field positions,
  reset values, event codes and the carrier structs for CPU event reports and fixed storage writes.
  Assumes a single clock domain and a plain register port.
*/
package etf_pkg;

  // Register offsets on the plain register port (word addresses).
  localparam logic [3:0] ETF_OFF_SELECT = 4'h0;
  localparam logic [3:0] ETF_OFF_START = 4'h1;
  localparam logic [3:0] ETF_OFF_END = 4'h2;
  localparam logic [3:0] ETF_OFF_STATUS = 4'h3;
  localparam logic [3:0] ETF_OFF_MASK = 4'h4;
  localparam logic [3:0] ETF_OFF_CODE = 4'h5;
  localparam logic [3:0] ETF_OFF_ADDR = 4'h6;

  // Field positions in the class and register select register and the status word mask bit.
  localparam int ETF_CLASS_BRANCH = 0;
  localparam int ETF_CLASS_GREG = 1;
  localparam int ETF_CLASS_FETCH = 2;
  localparam int ETF_CLASS_STORE = 3;
  localparam int ETF_GREG_SEL_LSB = 16;
  localparam int ETF_STATUS_WORD_MASK_BIT = 1;

  // Reset values.
  localparam logic [31:0] ETF_SELECT_RESET = 32'h0000_0000;
  localparam logic [31:0] ETF_START_RESET = 32'h0000_0000;
  localparam logic [31:0] ETF_END_RESET = 32'h0000_0000;
  localparam logic [3:0] ETF_IRQ_MASK_RESET = 4'h0;

  // Fixed storage locations written when the interruption is taken.
  localparam logic [23:0] ETF_LOC_CODE = 24'd150;
  localparam logic [23:0] ETF_LOC_ADDR = 24'd153;

  // Event code byte: one bit per class in the high nibble.
  localparam int ETF_CODE_SHIFT = 4;

  typedef struct packed {
    logic branch_taken;
    logic greg_write;
    logic [3:0] greg_num;
    logic fetch;
    logic store;
    logic [31:0] access_addr;
    logic [23:0] instr_addr;
  } etf_event_type;

  typedef struct packed {
    logic valid;
    logic [23:0] location;
    logic [31:0] data;
  } etf_store_type;

endpackage : etf_pkg
